// ==== core/ppo_pkg.sv ====
// shared constants for the port 0 real-time output block
package ppo_pkg;

  // register byte offsets
  localparam logic [4:0] PPO_OFF_DRIVE_MODE = 5'h00;
  localparam logic [4:0] PPO_OFF_RT_CTRL = 5'h04;
  localparam logic [4:0] PPO_OFF_LOW_BUF = 5'h08;
  localparam logic [4:0] PPO_OFF_HIGH_BUF = 5'h0C;
  localparam logic [4:0] PPO_OFF_LATCH = 5'h10;

  // real-time control register fields
  localparam int RTC_LOW_EN = 0;
  localparam int RTC_HIGH_EN = 1;
  localparam int RTC_PIN_TRIG = 2;
  localparam int RTC_FALL_EDGE = 3;
  localparam int RTC_SOFT_TRIG = 4;

  // drive-mode encodings and reset values
  localparam logic [7:0] DRIVE_ALL_ON = 8'h00;
  localparam logic [7:0] DRIVE_ALL_OFF = 8'hFF;
  localparam logic [7:0] DRIVE_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [3:0] BUF_RESET = 4'h0;
  localparam logic [7:0] OE_N_ALL_OFF = 8'hFF;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // synchroniser depth before logic may read the trigger pin
  localparam int SYNC_STAGES = 2;

endpackage : ppo_pkg

// ==== core/ppo_trig_sync.sv ====
// trigger pin synchroniser and edge detector
`timescale 1ns/1ps
module ppo_trig_sync import ppo_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pin and edge choice
  input wire logic extIrqPinZero,
  input wire logic fallEdge,
  // one-cycle event
  output logic edgePulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // only the second stage and later are looked at by logic
  always_comb begin
    nxt_meta = extIrqPinZero;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign edgePulse = fallEdge ? (last_ff & ~sync_ff) : (sync_ff & ~last_ff);

endmodule : ppo_trig_sync

// ==== core/ppo_pin_drive.sv ====
// port 0 pin driver: output enables and registered pin data
`timescale 1ns/1ps
module ppo_pin_drive import ppo_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic [7:0] driveMode,
  input wire logic lowRtEn,
  input wire logic highRtEn,
  input wire logic [7:0] latchData,
  // pins
  output logic [7:0] pinsOut,
  output logic [7:0] pinsOe_n
);

  logic [7:0] out_ff;
  logic [7:0] oeN_ff;
  logic [7:0] nxt_out;
  logic [7:0] nxt_oeN;

  always_comb begin
    nxt_out = latchData;
    // 00 drives all, FF floats all; other codes are unsupported and fall to per-bit
    nxt_oeN = driveMode;
    // a real-time group drives its pins whatever the drive mode holds
    if (lowRtEn) begin
      nxt_oeN[3:0] = 4'h0;
    end
    if (highRtEn) begin
      nxt_oeN[7:4] = 4'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_ff <= LATCH_RESET;
      oeN_ff <= OE_N_ALL_OFF;
    end else begin
      out_ff <= nxt_out;
      oeN_ff <= nxt_oeN;
    end
  end

  assign pinsOut = out_ff;
  assign pinsOe_n = oeN_ff;

endmodule : ppo_pin_drive

// ==== core/ppo_port0_rt.sv ====
// port 0 output port with real-time output and an AXI4-Lite register slave
`timescale 1ns/1ps

// Summary of operation
// - drive mode 00 turns all eight output buffers on and FF floats all eight pins.
// - the drive mode is loaded only by a whole-byte write and always reads back as zero.
// - reset sets the drive mode to FF so every pin floats.
// - after reset the pins float and the latch content is to be treated as undefined.
// - the real-time function runs as two 4-bit groups or, with both enabled, as one 8-bit group.
// - in real-time mode the pins show the group buffers, copied on each trigger.
// - software sets both group enables to make the port a full real-time port.
// - an enabled real-time group drives its pins from the latch whatever the drive mode.
// - the latch takes data from processor writes and holds it until loaded again.
// - processor writes to the latch are ignored for groups in real-time mode.
// - the latch always reads back its current contents, real-time mode or not.
// - the trigger can come from the external interrupt pin zero.
module ppo_port0_rt import ppo_pkg::*; #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pin
  input wire logic extIrqPinZero,
  // port pins
  output logic [7:0] port0PinsOut,
  output logic [7:0] port0PinsOe_n
);

  // replaces the enabled nibbles of old with those of fresh
  function automatic logic [7:0] mergeGroups(input logic [7:0] old, input logic [7:0] fresh,
                                             input logic lowSel, input logic highSel);
    logic [7:0] res;
    res = old;
    if (lowSel) begin
      res[3:0] = fresh[3:0];
    end
    if (highSel) begin
      res[7:4] = fresh[7:4];
    end
    return res;
  endfunction : mergeGroups

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    return (addr == ADDR_W'(PPO_OFF_DRIVE_MODE)) || (addr == ADDR_W'(PPO_OFF_RT_CTRL)) ||
           (addr == ADDR_W'(PPO_OFF_LOW_BUF)) || (addr == ADDR_W'(PPO_OFF_HIGH_BUF)) ||
           (addr == ADDR_W'(PPO_OFF_LATCH));
  endfunction : isMapped

  // bus state
  logic awHeld_ff, nxt_awHeld;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic wHeld_ff, nxt_wHeld;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;

  // port state
  logic [7:0] driveMode_ff, nxt_driveMode;
  logic lowEn_ff, nxt_lowEn;
  logic highEn_ff, nxt_highEn;
  logic pinTrigEn_ff, nxt_pinTrigEn;
  logic fallEdge_ff, nxt_fallEdge;
  logic [3:0] lowBuf_ff, nxt_lowBuf;
  logic [3:0] highBuf_ff, nxt_highBuf;
  logic [7:0] latch_ff, nxt_latch;

  logic commit;
  logic byteOk;
  logic latchWr;
  logic softTrig;
  logic pinEdge;
  logic trigger;

  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready = ~wHeld_ff;
  assign s_axi_arready = ~rValid_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // the response waits until the previous one is gone, so one write is in flight
  assign commit = awHeld_ff & wHeld_ff & ~bValid_ff;
  // only the low byte lane carries data; a write without it stores nothing
  assign byteOk = wStrb_ff[0];
  assign latchWr = commit & byteOk & (awAddr_ff == ADDR_W'(PPO_OFF_LATCH));
  assign softTrig = commit & byteOk & (awAddr_ff == ADDR_W'(PPO_OFF_RT_CTRL)) & wData_ff[RTC_SOFT_TRIG];
  assign trigger = softTrig | (pinTrigEn_ff & pinEdge);

  ppo_trig_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .extIrqPinZero(extIrqPinZero),
    .fallEdge(fallEdge_ff),
    .edgePulse(pinEdge)
  );

  ppo_pin_drive u_drive (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .driveMode(driveMode_ff),
    .lowRtEn(lowEn_ff),
    .highRtEn(highEn_ff),
    .latchData(latch_ff),
    .pinsOut(port0PinsOut),
    .pinsOe_n(port0PinsOe_n)
  );

  // bus channel handling
  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld = wHeld_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    if (s_axi_awvalid && !awHeld_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (commit) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = isMapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
    if (s_axi_arvalid && !rValid_ff) begin
      nxt_rValid = 1'b1;
      nxt_rResp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_rData = RDATA_ZERO;
      // the drive mode has no read path and returns zero
      if (s_axi_araddr == ADDR_W'(PPO_OFF_RT_CTRL)) begin
        nxt_rData[RTC_LOW_EN] = lowEn_ff;
        nxt_rData[RTC_HIGH_EN] = highEn_ff;
        nxt_rData[RTC_PIN_TRIG] = pinTrigEn_ff;
        nxt_rData[RTC_FALL_EDGE] = fallEdge_ff;
      end else if (s_axi_araddr == ADDR_W'(PPO_OFF_LOW_BUF)) begin
        nxt_rData[3:0] = lowBuf_ff;
      end else if (s_axi_araddr == ADDR_W'(PPO_OFF_HIGH_BUF)) begin
        nxt_rData[3:0] = highBuf_ff;
      end else if (s_axi_araddr == ADDR_W'(PPO_OFF_LATCH)) begin
        nxt_rData[7:0] = latch_ff;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= RDATA_ZERO;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff <= RDATA_ZERO;
      rResp_ff <= RESP_OKAY;
    end else begin
      awHeld_ff <= nxt_awHeld;
      awAddr_ff <= nxt_awAddr;
      wHeld_ff <= nxt_wHeld;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end
  end

  // port registers and output latch
  always_comb begin
    nxt_driveMode = driveMode_ff;
    nxt_lowEn = lowEn_ff;
    nxt_highEn = highEn_ff;
    nxt_pinTrigEn = pinTrigEn_ff;
    nxt_fallEdge = fallEdge_ff;
    nxt_lowBuf = lowBuf_ff;
    nxt_highBuf = highBuf_ff;
    nxt_latch = latch_ff;
    if (commit && byteOk) begin
      case (awAddr_ff)
        ADDR_W'(PPO_OFF_DRIVE_MODE): nxt_driveMode = wData_ff[7:0];
        ADDR_W'(PPO_OFF_RT_CTRL): begin
          // both enables set make the full 8-bit real-time port
          nxt_lowEn = wData_ff[RTC_LOW_EN];
          nxt_highEn = wData_ff[RTC_HIGH_EN];
          nxt_pinTrigEn = wData_ff[RTC_PIN_TRIG];
          nxt_fallEdge = wData_ff[RTC_FALL_EDGE];
        end
        ADDR_W'(PPO_OFF_LOW_BUF): nxt_lowBuf = wData_ff[3:0];
        ADDR_W'(PPO_OFF_HIGH_BUF): nxt_highBuf = wData_ff[3:0];
        default: ;
      endcase
    end
    // cpu writes reach only groups not in real-time mode
    if (latchWr) begin
      nxt_latch = mergeGroups(latch_ff, wData_ff[7:0], ~lowEn_ff, ~highEn_ff);
    end
    // a trigger lands both enabled groups together in one cycle
    if (trigger) begin
      nxt_latch = mergeGroups(nxt_latch, {highBuf_ff, lowBuf_ff}, lowEn_ff, highEn_ff);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      driveMode_ff <= DRIVE_RESET;
      lowEn_ff <= 1'b0;
      highEn_ff <= 1'b0;
      pinTrigEn_ff <= 1'b0;
      fallEdge_ff <= 1'b0;
      lowBuf_ff <= BUF_RESET;
      highBuf_ff <= BUF_RESET;
      // reset value only keeps simulation clean; software must not rely on it
      latch_ff <= LATCH_RESET;
    end else begin
      driveMode_ff <= nxt_driveMode;
      lowEn_ff <= nxt_lowEn;
      highEn_ff <= nxt_highEn;
      pinTrigEn_ff <= nxt_pinTrigEn;
      fallEdge_ff <= nxt_fallEdge;
      lowBuf_ff <= nxt_lowBuf;
      highBuf_ff <= nxt_highBuf;
      latch_ff <= nxt_latch;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_drive_reset_value: assert property ($past(sys_rst) |-> driveMode_ff == DRIVE_RESET)
    else $error("drive mode not FF after reset");
  a_pins_float_reset: assert property ($past(sys_rst) |-> port0PinsOe_n == OE_N_ALL_OFF)
    else $error("pins driven right after reset");
  a_mode_all_on: assert property ((driveMode_ff == DRIVE_ALL_ON) |=> port0PinsOe_n == 8'h00)
    else $error("mode 00 did not enable all buffers");
  a_mode_all_off: assert property ((driveMode_ff == DRIVE_ALL_OFF && !lowEn_ff && !highEn_ff)
    |=> port0PinsOe_n == OE_N_ALL_OFF)
    else $error("mode FF did not float pins");
  a_mode_no_read: assert property ((s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == ADDR_W'(PPO_OFF_DRIVE_MODE)) |=> s_axi_rvalid && s_axi_rdata == RDATA_ZERO)
    else $error("drive mode readable");
  a_mode_byte_only: assert property ((commit && !byteOk) |=> $stable(driveMode_ff))
    else $error("drive mode changed without low byte lane");
  a_rt_drives_pins: assert property ((lowEn_ff && highEn_ff) |=> port0PinsOe_n == 8'h00 &&
    port0PinsOut == $past(latch_ff))
    else $error("real-time port not driving latch");
  a_latch_readback: assert property ((s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == ADDR_W'(PPO_OFF_LATCH)) |=> s_axi_rdata[7:0] == $past(latch_ff))
    else $error("latch read wrong");
  a_latch_wr_blocked: assert property ((latchWr && lowEn_ff && !trigger)
    |=> latch_ff[3:0] == $past(latch_ff[3:0]))
    else $error("latch write not ignored in real-time mode");
  a_latch_holds: assert property ((!latchWr && !trigger) |=> $stable(latch_ff))
    else $error("latch changed without a load");
  a_trig_copy: assert property ((trigger && lowEn_ff && !highEn_ff && !latchWr)
    |=> latch_ff == {$past(latch_ff[7:4]), $past(lowBuf_ff)})
    else $error("trigger copy wrong");
  a_trig_byte: assert property ((trigger && lowEn_ff && highEn_ff)
    |=> latch_ff == {$past(highBuf_ff), $past(lowBuf_ff)})
    else $error("8-bit real-time copy wrong");
  a_pin_trigger: assert property ((pinEdge && pinTrigEn_ff && highEn_ff)
    |=> latch_ff[7:4] == $past(highBuf_ff) ##1 port0PinsOut[7:4] == $past(highBuf_ff, 2))
    else $error("pin trigger not reaching pins");

  c_byte_trigger: cover property (trigger && lowEn_ff && highEn_ff);
  c_mode_on: cover property (commit && byteOk && awAddr_ff == ADDR_W'(PPO_OFF_DRIVE_MODE) &&
    wData_ff[7:0] == DRIVE_ALL_ON);
  c_ignored_write: cover property (latchWr && lowEn_ff && highEn_ff);
  c_pin_edge: cover property (pinEdge && pinTrigEn_ff);

endmodule : ppo_port0_rt

// ==== test/ppo_load_model.sv ====
// behavioural loads on the port 0 pins
`timescale 1ns/1ps
module ppo_load_model (
  // clock
  input wire logic core_clk,
  // pins from the block
  input wire logic [7:0] pinsOut,
  input wire logic [7:0] pinsOe_n,
  // level seen at the loads
  output logic [7:0] padLevel
);
  logic [7:0] lastLevel = 8'h00;
  // no pull-up on this port: a floating pin toggles so it never passes for a held value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      padLevel[i] = pinsOe_n[i] ? ~lastLevel[i] : pinsOut[i];
    end
  end
  always_ff @(posedge core_clk) begin
    lastLevel <= padLevel;
  end
endmodule : ppo_load_model

// ==== test/test_ppo_port0_rt.sv ====
// self-checking bench for the port 0 real-time output block
`timescale 1ns/1ps
module test_ppo_port0_rt import ppo_pkg::*;;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] sAwaddr = 5'h00;
  logic [4:0] sAraddr = 5'h00;
  logic [31:0] sWdata = 32'h0;
  logic [3:0] sWstrb = 4'h0;
  logic sAwvalid = 1'b0;
  logic sWvalid = 1'b0;
  logic sBready = 1'b0;
  logic sArvalid = 1'b0;
  logic sRready = 1'b0;
  logic extIrqPinZero = 1'b0;
  logic sAwready, sWready, sBvalid, sArready, sRvalid;
  logic [1:0] sBresp, sRresp;
  logic [31:0] sRdata;
  logic [7:0] pinsOut, pinsOe_n, padLevel;
  int err_count = 0;
  int cmp_count = 0;
  logic [33:0] rdQ[$];

  always #5 core_clk = ~core_clk;

  ppo_port0_rt #(.ADDR_W(5)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(sAwaddr), .s_axi_awvalid(sAwvalid), .s_axi_awready(sAwready),
    .s_axi_wdata(sWdata), .s_axi_wstrb(sWstrb), .s_axi_wvalid(sWvalid), .s_axi_wready(sWready),
    .s_axi_bresp(sBresp), .s_axi_bvalid(sBvalid), .s_axi_bready(sBready),
    .s_axi_araddr(sAraddr), .s_axi_arvalid(sArvalid), .s_axi_arready(sArready),
    .s_axi_rdata(sRdata), .s_axi_rresp(sRresp), .s_axi_rvalid(sRvalid), .s_axi_rready(sRready),
    .extIrqPinZero(extIrqPinZero), .port0PinsOut(pinsOut), .port0PinsOe_n(pinsOe_n)
  );

  ppo_load_model u_load (.core_clk(core_clk), .pinsOut(pinsOut), .pinsOe_n(pinsOe_n), .padLevel(padLevel));

  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic expire;
    err_count++;
    $display("MISMATCH t=%0t bus wait ran out", $time);
    stop_test();
  endtask : expire

  // write: address and data offered together, bready held until bvalid is seen
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    sAwaddr <= a;
    sWdata <= d;
    sWstrb <= s;
    sAwvalid <= 1'b1;
    sWvalid <= 1'b1;
    sBready <= 1'b1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      // each valid drops once, at its own handshake edge; bready simply stays up
      if (sAwvalid && sAwready === 1'b1) sAwvalid <= 1'b0;
      if (sWvalid && sWready === 1'b1) sWvalid <= 1'b0;
      if (sBvalid === 1'b1) break;
    end
    if (sBvalid !== 1'b1) expire();
    chk(34'(sBresp), 34'(er));
  endtask : wr

  // read: the expected word is noted and the monitor compares it
  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    rdQ.push_back({er, d});
    sAraddr <= a;
    sArvalid <= 1'b1;
    sRready <= 1'b1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      if (sArvalid && sArready === 1'b1) sArvalid <= 1'b0;
      if (sRvalid === 1'b1) break;
    end
    if (sRvalid !== 1'b1) expire();
  endtask : rd

  always @(posedge core_clk) begin
    if (sRvalid === 1'b1 && sRready === 1'b1) begin
      if (rdQ.size() == 0) begin
        err_count++;
        $display("MISMATCH t=%0t read data with nothing expected", $time);
      end else begin
        chk({sRresp, sRdata}, rdQ.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    expire();
  end

  initial begin
    logic [7:0] lat;
    logic [3:0] lb, hb;
    void'($urandom(32'h0BEA2BF7));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(OE_N_ALL_OFF));
    chk(34'(pinsOe_n), 34'(DRIVE_RESET));
    rd(PPO_OFF_DRIVE_MODE, RDATA_ZERO, RESP_OKAY);
    rd(5'h14, RDATA_ZERO, RESP_SLVERR);
    wr(5'h14, 32'h0000_00AA, 4'hF, RESP_SLVERR);
    lat = 8'($urandom);
    wr(PPO_OFF_LATCH, 32'(lat), 4'h1, RESP_OKAY);
    wr(PPO_OFF_DRIVE_MODE, 32'(DRIVE_ALL_ON), 4'h1, RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'h00));
    chk(34'(padLevel), 34'(lat));
    // a write with no byte lane strobed must not touch the drive mode
    wr(PPO_OFF_DRIVE_MODE, 32'(DRIVE_ALL_OFF), 4'h0, RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'h00));
    rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
    // mixed codes are unsupported; here each 0 bit drives its own pin
    wr(PPO_OFF_DRIVE_MODE, 32'h0000_00A5, 4'h1, RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'hA5));
    wr(PPO_OFF_DRIVE_MODE, 32'(DRIVE_ALL_OFF), 4'h1, RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'hFF));
    // low group alone with a soft trigger: high nibble of the latch stays
    lb = 4'($urandom);
    hb = 4'($urandom);
    wr(PPO_OFF_LOW_BUF, 32'(lb), 4'h1, RESP_OKAY);
    wr(PPO_OFF_HIGH_BUF, 32'(hb), 4'h1, RESP_OKAY);
    // the trigger sees the enables already registered, so the group is switched on first
    wr(PPO_OFF_RT_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
    wr(PPO_OFF_RT_CTRL, 32'h0000_0011, 4'h1, RESP_OKAY);
    lat = {lat[7:4], lb};
    rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'hF0));
    chk(34'(pinsOut), 34'(lat));
    wr(PPO_OFF_LATCH, 32'(~lat), 4'h1, RESP_OKAY);
    lat = {~lat[7:4], lat[3:0]};
    rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
    // both groups from the pin, rising then falling edge
    for (int i = 0; i < 2; i++) begin
      lb = 4'($urandom);
      hb = 4'($urandom);
      wr(PPO_OFF_LOW_BUF, 32'(lb), 4'h1, RESP_OKAY);
      wr(PPO_OFF_HIGH_BUF, 32'(hb), 4'h1, RESP_OKAY);
      wr(PPO_OFF_RT_CTRL, 32'h0000_0007 | 32'(i << 3), 4'h1, RESP_OKAY);
      rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
      extIrqPinZero <= (i == 0);
      repeat (8) @(posedge core_clk);
      lat = {hb, lb};
      rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
      @(posedge core_clk);
      chk(34'(padLevel), 34'(lat));
      chk(34'(pinsOe_n), 34'(8'h00));
      wr(PPO_OFF_LATCH, 32'(~lat), 4'h1, RESP_OKAY);
      rd(PPO_OFF_LATCH, 32'(lat), RESP_OKAY);
    end
    wr(PPO_OFF_RT_CTRL, 32'h0, 4'h1, RESP_OKAY);
    @(posedge core_clk);
    chk(34'(pinsOe_n), 34'(8'hFF));
    repeat (2) @(posedge core_clk);
    chk(34'(rdQ.size()), 34'(0));
    stop_test();
  end
endmodule : test_ppo_port0_rt
